// >>> pdc_pkg.sv
// Purpose: Shared constants and types for the loop divider configuration bank.
// Assumes: Byte-wide registers reached over a plain strobe port.
// Notes:   Offsets are byte addresses of the configuration space.
package pdc_pkg;

  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;

  localparam logic [12:0] OFS_REF0_LO  = 13'h0154;
  localparam logic [12:0] OFS_REF1_HI  = 13'h0155;
  localparam logic [12:0] OFS_REF1_LO  = 13'h0156;
  localparam logic [12:0] OFS_REF2_HI  = 13'h0157;
  localparam logic [12:0] OFS_REF2_LO  = 13'h0158;
  localparam logic [12:0] OFS_L1FB_HI  = 13'h0159;
  localparam logic [12:0] OFS_L1FB_LO  = 13'h015A;
  localparam logic [12:0] OFS_L1PD     = 13'h015B;
  localparam logic [12:0] OFS_L1LC_HI  = 13'h015C;
  localparam logic [12:0] OFS_L1LC_LO  = 13'h015D;
  localparam logic [12:0] OFS_L1DLY    = 13'h015E;
  localparam logic [12:0] OFS_ST1      = 13'h015F;
  localparam logic [12:0] OFS_L2R_HI   = 13'h0160;
  localparam logic [12:0] OFS_L2R_LO   = 13'h0161;
  localparam logic [12:0] OFS_L2OPT    = 13'h0162;
  localparam logic [12:0] OFS_L2CAL_T  = 13'h0163;
  localparam logic [12:0] OFS_L2CAL_M  = 13'h0164;
  localparam logic [12:0] OFS_L2CAL_L  = 13'h0165;
  localparam logic [12:0] OFS_L2FB_T   = 13'h0166;
  localparam logic [12:0] OFS_L2FB_M   = 13'h0167;
  localparam logic [12:0] OFS_L2FB_L   = 13'h0168;

  // Writable bit masks; everything else reads zero.
  localparam logic [7:0] MASK_HI6  = 8'h3F;
  localparam logic [7:0] MASK_HI4  = 8'h0F;
  localparam logic [7:0] MASK_TOP2 = 8'h03;
  localparam logic [7:0] MASK_FBT  = 8'h07;
  localparam logic [7:0] MASK_DLY  = 8'h3F;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  localparam logic [7:0] RST_REF0_LO = 8'h78;
  localparam logic [7:0] RST_REF_LO  = 8'h96;
  localparam logic [7:0] RST_L1FB_LO = 8'h78;
  localparam logic [7:0] RST_L1PD    = 8'hD4;
  localparam logic [7:0] RST_L1LC_HI = 8'h20;
  localparam logic [7:0] RST_ST1     = 8'h0E;
  localparam logic [7:0] RST_L2R_LO  = 8'h02;
  localparam logic [7:0] RST_L2OPT   = 8'h5D;
  localparam logic [7:0] RST_L2N_LO  = 8'h0C;
  localparam logic [7:0] RST_ZERO    = 8'h00;

  localparam int unsigned FCAL_DIS_BIT = 2;

  localparam logic [2:0] DRV_PUSH_PULL = 3'h3;
  localparam logic [2:0] DRV_INVERTED  = 3'h4;
  localparam logic [2:0] DRV_OPEN_DRN  = 3'h6;

  localparam logic [4:0] SEL_LOW      = 5'h00;
  localparam logic [4:0] SEL_L1_LOCK  = 5'h01;
  localparam logic [4:0] SEL_L2_LOCK  = 5'h02;
  localparam logic [4:0] SEL_BOTH     = 5'h03;

  // Decoded configuration towards the analog loops.
  typedef struct packed {
    logic [13:0] ref0_divider;
    logic [13:0] ref1_divider;
    logic [13:0] ref2_divider;
    logic [13:0] loop1_feedback_divider;
    logic [1:0]  loop1_phase_window;
    logic        loop1_pump_highz;
    logic        loop1_pump_polarity;
    logic [3:0]  loop1_pump_current;
    logic [13:0] loop1_lock_count;
    logic [2:0]  loop1_ref_delay;
    logic [2:0]  loop1_fb_delay;
    logic [4:0]  status1_select;
    logic [2:0]  status1_drive_type;
    logic [11:0] loop2_ref_divider;
    logic [3:0]  loop2_prescaler;
    logic [2:0]  loop2_ref_range;
    logic        crystal_amp_enable;
    logic        ref_doubler_enable;
    logic [17:0] loop2_active_feedback;
    logic        freq_cal_disable;
  } pdc_cfg_t;

endpackage : pdc_pkg

// >>> pdc_bank.sv
// Purpose: Configuration register bank for a dual-loop clock conditioner.
// Assumes: Software is the only party at the registers; one clock, mclk.
// Notes:   Calibration runtime is a parameter, the analog routine is modelled
//          as a busy window.
//
// Overview of operation
// - Second reference divider is 14 bits over two bytes, low byte resets to 150.
// - Third reference divider is 14 bits over two bytes, zero reserved.
// - First-loop feedback divider is 14 bits, low byte resets to 120.
// - Phase window code in bits 7:6 resets to 3.
// - Bit 5 puts the first-loop pump output in high impedance.
// - Bit 4 is pump polarity, resets to positive slope.
// - Pump current code in bits 3:0 resets to 4.
// - Lock detect count is 14 bits, upper byte resets to 32.
// - Reference-path delay code in bits 5:3 resets to zero.
// - Feedback-path delay code in bits 2:0 resets to zero.
// - Status pin selector in bits 7:3 resets to code 1.
// - Status pin drive type in bits 2:0 resets to open drain.
// - Second-loop reference divider is 12 bits, low byte resets to 2.
// - Prescaler code 0 divides by 8, code 1 by 2, others by themselves.
// - Bit 1 enables the crystal amplifier, resets disabled.
// - Bit 0 enables the reference doubler, resets enabled.
// - Calibration uses the calibration divider, then the normal feedback divider.
// - No zero-delay feedback while calibration runs.
// - Writing the lowest feedback byte starts calibration unless disabled.
// - Second-loop feedback divider is 18 bits, low byte resets to 12.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

module pdc_bank
  import pdc_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = 64
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [12:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [7:0]        reg_rdata,
  input  wire logic              loop1_lock_raw,
  input  wire logic              loop2_lock_raw,
  input  wire logic              zero_delay_request,
  output pdc_cfg_t               cfg,
  output logic                   cal_busy,
  output logic                   loop2_zero_delay_en,
  output logic                   status_pin_one_out,
  output logic                   status_pin_one_oe
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ref0_lo;
    logic [7:0]  ref1_hi;
    logic [7:0]  ref1_lo;
    logic [7:0]  ref2_hi;
    logic [7:0]  ref2_lo;
    logic [7:0]  l1fb_hi;
    logic [7:0]  l1fb_lo;
    logic [7:0]  l1pd;
    logic [7:0]  l1lc_hi;
    logic [7:0]  l1lc_lo;
    logic [7:0]  l1dly;
    logic [7:0]  st1;
    logic [7:0]  l2r_hi;
    logic [7:0]  l2r_lo;
    logic [7:0]  l2opt;
    logic [7:0]  l2cal_t;
    logic [7:0]  l2cal_m;
    logic [7:0]  l2cal_l;
    logic [7:0]  l2fb_t;
    logic [7:0]  l2fb_m;
    logic [7:0]  l2fb_l;
    logic [7:0]  rdata;
    logic        cal_run;
    logic [15:0] cal_cnt;
    logic [1:0]  l1_sync;
    logic [1:0]  l2_sync;
    logic [1:0]  zd_sync;
  } pdc_state_t;

  pdc_state_t st;
  pdc_state_t next_st;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [7:0] mask_for(input logic [12:0] a);
    if (a == OFS_REF1_HI || a == OFS_REF2_HI || a == OFS_L1FB_HI || a == OFS_L1LC_HI) begin
      mask_for = MASK_HI6;
    end else if (a == OFS_L1DLY) begin
      mask_for = MASK_DLY;
    end else if (a == OFS_L2R_HI) begin
      mask_for = MASK_HI4;
    end else if (a == OFS_L2CAL_T) begin
      mask_for = MASK_TOP2;
    end else if (a == OFS_L2FB_T) begin
      mask_for = MASK_FBT;
    end else begin
      mask_for = MASK_FULL;
    end
  endfunction

  function automatic logic [3:0] prescale(input logic [2:0] code);
    if (code == 3'h0) begin
      prescale = 4'h8;
    end else if (code == 3'h1) begin
      prescale = 4'h2;
    end else begin
      prescale = {1'b0, code};
    end
  endfunction

  logic [7:0] wmask;
  logic [7:0] wval;
  logic       cal_start;

  assign wmask = mask_for(reg_addr);
  assign wval  = reg_wdata & wmask;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    next_st         = st;
    cal_start       = 1'b0;
    next_st.l1_sync = {st.l1_sync[0], loop1_lock_raw};
    next_st.l2_sync = {st.l2_sync[0], loop2_lock_raw};
    next_st.zd_sync = {st.zd_sync[0], zero_delay_request};
    if (reg_write) begin
      if (reg_addr == OFS_REF0_LO) begin
        next_st.ref0_lo = wval;
      end else if (reg_addr == OFS_REF1_HI) begin
        next_st.ref1_hi = wval;
      end else if (reg_addr == OFS_REF1_LO) begin
        next_st.ref1_lo = wval;
      end else if (reg_addr == OFS_REF2_HI) begin
        next_st.ref2_hi = wval;
      end else if (reg_addr == OFS_REF2_LO) begin
        next_st.ref2_lo = wval;
      end else if (reg_addr == OFS_L1FB_HI) begin
        next_st.l1fb_hi = wval;
      end else if (reg_addr == OFS_L1FB_LO) begin
        next_st.l1fb_lo = wval;
      end else if (reg_addr == OFS_L1PD) begin
        next_st.l1pd = wval;
      end else if (reg_addr == OFS_L1LC_HI) begin
        next_st.l1lc_hi = wval;
      end else if (reg_addr == OFS_L1LC_LO) begin
        next_st.l1lc_lo = wval;
      end else if (reg_addr == OFS_L1DLY) begin
        next_st.l1dly = wval;
      end else if (reg_addr == OFS_ST1) begin
        next_st.st1 = wval;
      end else if (reg_addr == OFS_L2R_HI) begin
        next_st.l2r_hi = wval;
      end else if (reg_addr == OFS_L2R_LO) begin
        next_st.l2r_lo = wval;
      end else if (reg_addr == OFS_L2OPT) begin
        next_st.l2opt = wval;
      end else if (reg_addr == OFS_L2CAL_T) begin
        next_st.l2cal_t = wval;
      end else if (reg_addr == OFS_L2CAL_M) begin
        next_st.l2cal_m = wval;
      end else if (reg_addr == OFS_L2CAL_L) begin
        next_st.l2cal_l = wval;
      end else if (reg_addr == OFS_L2FB_T) begin
        next_st.l2fb_t = wval;
      end else if (reg_addr == OFS_L2FB_M) begin
        next_st.l2fb_m = wval;
      end else if (reg_addr == OFS_L2FB_L) begin
        next_st.l2fb_l = wval;
        cal_start      = ~st.l2fb_t[FCAL_DIS_BIT];
      end
    end
    // A new start restarts the routine from its beginning.
    if (cal_start) begin
      next_st.cal_run = 1'b1;
      next_st.cal_cnt = 16'(CAL_CYCLES);
    end else if (st.cal_run) begin
      if (st.cal_cnt <= 16'h0001) begin
        next_st.cal_run = 1'b0;
        next_st.cal_cnt = 16'h0000;
      end else begin
        next_st.cal_cnt = st.cal_cnt - 16'h0001;
      end
    end
    next_st.rdata = 8'h00;
    if (reg_read) begin
      if (reg_addr == OFS_REF0_LO) begin
        next_st.rdata = st.ref0_lo;
      end else if (reg_addr == OFS_REF1_HI) begin
        next_st.rdata = st.ref1_hi;
      end else if (reg_addr == OFS_REF1_LO) begin
        next_st.rdata = st.ref1_lo;
      end else if (reg_addr == OFS_REF2_HI) begin
        next_st.rdata = st.ref2_hi;
      end else if (reg_addr == OFS_REF2_LO) begin
        next_st.rdata = st.ref2_lo;
      end else if (reg_addr == OFS_L1FB_HI) begin
        next_st.rdata = st.l1fb_hi;
      end else if (reg_addr == OFS_L1FB_LO) begin
        next_st.rdata = st.l1fb_lo;
      end else if (reg_addr == OFS_L1PD) begin
        next_st.rdata = st.l1pd;
      end else if (reg_addr == OFS_L1LC_HI) begin
        next_st.rdata = st.l1lc_hi;
      end else if (reg_addr == OFS_L1LC_LO) begin
        next_st.rdata = st.l1lc_lo;
      end else if (reg_addr == OFS_L1DLY) begin
        next_st.rdata = st.l1dly;
      end else if (reg_addr == OFS_ST1) begin
        next_st.rdata = st.st1;
      end else if (reg_addr == OFS_L2R_HI) begin
        next_st.rdata = st.l2r_hi;
      end else if (reg_addr == OFS_L2R_LO) begin
        next_st.rdata = st.l2r_lo;
      end else if (reg_addr == OFS_L2OPT) begin
        next_st.rdata = st.l2opt;
      end else if (reg_addr == OFS_L2CAL_T) begin
        next_st.rdata = st.l2cal_t;
      end else if (reg_addr == OFS_L2CAL_M) begin
        next_st.rdata = st.l2cal_m;
      end else if (reg_addr == OFS_L2CAL_L) begin
        next_st.rdata = st.l2cal_l;
      end else if (reg_addr == OFS_L2FB_T) begin
        next_st.rdata = st.l2fb_t;
      end else if (reg_addr == OFS_L2FB_M) begin
        next_st.rdata = st.l2fb_m;
      end else if (reg_addr == OFS_L2FB_L) begin
        next_st.rdata = st.l2fb_l;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st         <= '0;
      st.ref0_lo <= RST_REF0_LO;
      st.ref1_lo <= RST_REF_LO;
      st.ref2_lo <= RST_REF_LO;
      st.l1fb_lo <= RST_L1FB_LO;
      st.l1pd    <= RST_L1PD;
      st.l1lc_hi <= RST_L1LC_HI;
      st.l1dly   <= RST_ZERO;
      st.st1     <= RST_ST1;
      st.l2r_lo  <= RST_L2R_LO;
      st.l2opt   <= RST_L2OPT;
      st.l2cal_l <= RST_L2N_LO;
      st.l2fb_l  <= RST_L2N_LO;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  logic status_level;

  always_comb begin
    cfg.ref0_divider           = {6'h00, st.ref0_lo};
    cfg.ref1_divider           = {st.ref1_hi[5:0], st.ref1_lo};
    cfg.ref2_divider           = {st.ref2_hi[5:0], st.ref2_lo};
    cfg.loop1_feedback_divider = {st.l1fb_hi[5:0], st.l1fb_lo};
    cfg.loop1_phase_window     = st.l1pd[7:6];
    cfg.loop1_pump_highz       = st.l1pd[5];
    cfg.loop1_pump_polarity    = st.l1pd[4];
    cfg.loop1_pump_current     = st.l1pd[3:0];
    cfg.loop1_lock_count       = {st.l1lc_hi[5:0], st.l1lc_lo};
    cfg.loop1_ref_delay        = st.l1dly[5:3];
    cfg.loop1_fb_delay         = st.l1dly[2:0];
    cfg.status1_select         = st.st1[7:3];
    cfg.status1_drive_type     = st.st1[2:0];
    cfg.loop2_ref_divider      = {st.l2r_hi[3:0], st.l2r_lo};
    cfg.loop2_prescaler        = prescale(st.l2opt[7:5]);
    cfg.loop2_ref_range        = st.l2opt[4:2];
    cfg.crystal_amp_enable     = st.l2opt[1];
    cfg.ref_doubler_enable     = st.l2opt[0];
    cfg.freq_cal_disable       = st.l2fb_t[FCAL_DIS_BIT];
    if (st.cal_run) begin
      cfg.loop2_active_feedback = {st.l2cal_t[1:0], st.l2cal_m, st.l2cal_l};
    end else begin
      cfg.loop2_active_feedback = {st.l2fb_t[1:0], st.l2fb_m, st.l2fb_l};
    end
  end

  always_comb begin
    if (st.st1[7:3] == SEL_L1_LOCK) begin
      status_level = st.l1_sync[1];
    end else if (st.st1[7:3] == SEL_L2_LOCK) begin
      status_level = st.l2_sync[1];
    end else if (st.st1[7:3] == SEL_BOTH) begin
      status_level = st.l1_sync[1] & st.l2_sync[1];
    end else begin
      status_level = 1'b0;
    end
  end

  always_comb begin
    if (st.st1[2:0] == DRV_PUSH_PULL) begin
      status_pin_one_out = status_level;
      status_pin_one_oe  = 1'b1;
    end else if (st.st1[2:0] == DRV_INVERTED) begin
      status_pin_one_out = ~status_level;
      status_pin_one_oe  = 1'b1;
    end else if (st.st1[2:0] == DRV_OPEN_DRN) begin
      status_pin_one_out = 1'b0;
      status_pin_one_oe  = ~status_level;
    end else begin
      status_pin_one_out = 1'b0;
      status_pin_one_oe  = 1'b0;
    end
  end

  assign reg_rdata           = st.rdata;
  assign cal_busy            = st.cal_run;
  assign loop2_zero_delay_en = st.zd_sync[1] & ~st.cal_run;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  chk_cal_start_write: assert property (@(posedge mclk) disable iff (reset)
    (reg_write && reg_addr == OFS_L2FB_L && !st.l2fb_t[FCAL_DIS_BIT]) |=> cal_busy)
    else $error("calibration did not start");
  chk_cal_disabled: assert property (@(posedge mclk) disable iff (reset)
    (reg_write && reg_addr == OFS_L2FB_L && st.l2fb_t[FCAL_DIS_BIT] && !cal_busy) |=> !cal_busy)
    else $error("calibration started while disabled");
  chk_no_zero_delay: assert property (@(posedge mclk) disable iff (reset)
    cal_busy |-> !loop2_zero_delay_en)
    else $error("zero delay during calibration");
  chk_cal_divider_sel: assert property (@(posedge mclk) disable iff (reset)
    cal_busy |-> cfg.loop2_active_feedback == {st.l2cal_t[1:0], st.l2cal_m, st.l2cal_l})
    else $error("wrong divider during calibration");
  chk_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
    (reg_read && reg_addr == OFS_REF1_HI) |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved bits not zero");
  chk_write_readback: assert property (@(posedge mclk) disable iff (reset)
    (reg_write && reg_addr == OFS_L1PD) ##1 (reg_read && reg_addr == OFS_L1PD && !reg_write)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("phase detector readback mismatch");
  chk_prescale_zero: assert property (@(posedge mclk) disable iff (reset)
    st.l2opt[7:5] == 3'h0 |-> cfg.loop2_prescaler == 4'h8)
    else $error("prescaler code zero not eight");
  chk_open_drain: assert property (@(posedge mclk) disable iff (reset)
    (st.st1[2:0] == DRV_OPEN_DRN) |-> !status_pin_one_out)
    else $error("open drain drives high");
  chk_read_idle: assert property (@(posedge mclk) disable iff (reset)
    !$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_inverted_drive: assert property (@(posedge mclk) disable iff (reset)
    (st.st1[2:0] == DRV_INVERTED) |-> status_pin_one_oe && status_pin_one_out == !status_level)
    else $error("inverted drive wrong");
  chk_reserved_type: assert property (@(posedge mclk) disable iff (reset)
    (st.st1[2:0] != DRV_PUSH_PULL && st.st1[2:0] != DRV_INVERTED
     && st.st1[2:0] != DRV_OPEN_DRN) |-> !status_pin_one_oe)
    else $error("reserved drive type enables pin");
  chk_normal_divider: assert property (@(posedge mclk) disable iff (reset)
    !cal_busy |-> cfg.loop2_active_feedback == {st.l2fb_t[1:0], st.l2fb_m, st.l2fb_l})
    else $error("wrong divider outside calibration");

  cov_cal_run: cover property (@(posedge mclk) disable iff (reset) $rose(cal_busy));
  cov_cal_end: cover property (@(posedge mclk) disable iff (reset) $fell(cal_busy));
  cov_push_pull: cover property (@(posedge mclk) disable iff (reset)
    st.st1[2:0] == DRV_PUSH_PULL && status_pin_one_out);
  cov_open_drain: cover property (@(posedge mclk) disable iff (reset)
    st.st1[2:0] == DRV_OPEN_DRN && status_pin_one_oe);

endmodule // pdc_bank

// >>> tb.sv
// Purpose: Self-checking bench for the loop divider configuration bank.
// Assumes: Strobe register port with read data one cycle after the read strobe.
// Notes:   Calibration runtime is shortened to CAL_N cycles.
`timescale 1ns/1ps

module tb;
  import pdc_pkg::*;
  localparam int unsigned CAL_N = 4;
  localparam logic [7:0] RST_TAB [21] = '{8'h78, 8'h00, 8'h96, 8'h00, 8'h96, 8'h00, 8'h78,
    8'hD4, 8'h20, 8'h00, 8'h00, 8'h0E, 8'h00, 8'h02, 8'h5D, 8'h00, 8'h00, 8'h0C, 8'h00,
    8'h00, 8'h0C};
  localparam logic [7:0] MSK_TAB [21] = '{8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF,
    8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h07,
    8'hFF, 8'hFF};

  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [12:0] reg_addr = '0;
  logic [7:0]  reg_wdata = '0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [7:0]  reg_rdata;
  logic        loop1_lock_raw = 1'b0;
  logic        loop2_lock_raw = 1'b0;
  logic        zero_delay_request = 1'b1;
  pdc_cfg_t    cfg;
  logic        cal_busy;
  logic        loop2_zero_delay_en;
  logic        status_pin_one_out;
  logic        status_pin_one_oe;
  int          fails = 0;
  int          n_checks = 0;
  int          n;
  logic [3:0]  exp_p;

  always #20 mclk = ~mclk;

  pdc_bank #(.CAL_CYCLES(CAL_N)) dut_u (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .loop1_lock_raw(loop1_lock_raw), .loop2_lock_raw(loop2_lock_raw),
    .zero_delay_request(zero_delay_request), .cfg(cfg), .cal_busy(cal_busy),
    .loop2_zero_delay_en(loop2_zero_delay_en), .status_pin_one_out(status_pin_one_out),
    .status_pin_one_oe(status_pin_one_oe));

  // ----------------------------------------------------------------
  // Access and checking tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  // Read data is taken in the single cycle after the read strobe edge.
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic st(input logic [7:0] v, input logic l1, input logic l2,
                    input logic eo, input logic eoe);
    wr(OFS_ST1, v);
    loop1_lock_raw <= l1;
    loop2_lock_raw <= l2;
    repeat (5) @(posedge mclk);
    #1;
    chk(status_pin_one_oe, eoe);
    if (eoe) chk(status_pin_one_out, eo);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 21; i++) begin
      rd(13'h154 + 13'(i), d);
      chk(d, RST_TAB[i]);
    end
    chk(cfg.ref1_divider, 18'd150);
    chk(cfg.loop1_lock_count, 18'h2000);
    chk({cfg.loop1_phase_window, cfg.loop1_pump_highz, cfg.loop1_pump_polarity,
         cfg.loop1_pump_current}, 18'hD4);
    chk(cfg.loop2_active_feedback, 18'd12);
    // All-ones writes set the calibration-disable bit before the lowest byte.
    for (int i = 0; i < 21; i++) wr(13'h154 + 13'(i), 8'hFF);
    repeat (2) @(posedge mclk);
    chk(cal_busy, 1'b0);
    for (int i = 0; i < 21; i++) begin
      rd(13'h154 + 13'(i), d);
      chk(d, MSK_TAB[i]);
    end
    chk(cfg.ref2_divider, 18'h3FFF);
    chk(cfg.loop1_feedback_divider, 18'h3FFF);
    chk({cfg.loop1_ref_delay, cfg.loop1_fb_delay}, 18'h3F);
    chk(cfg.loop2_ref_divider, 18'hFFF);
    wr(13'h0169, 8'h5A);
    rd(13'h0169, d);
    chk(d, 8'h00);
    rd(13'h0153, d);
    chk(d, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_L2OPT, {3'(c), 3'(c % 3), 2'(c)});
      #1;
      exp_p = (c == 0) ? 4'h8 : (c == 1) ? 4'h2 : 4'(c);
      chk(cfg.loop2_prescaler, exp_p);
      chk({cfg.loop2_ref_range, cfg.crystal_amp_enable, cfg.ref_doubler_enable},
          {3'(c % 3), 2'(c)});
    end
    // Calibration run with the zero-delay feedback requested throughout.
    wr(OFS_L2FB_T, 8'h00);
    wr(OFS_L2FB_M, 8'h01);
    wr(OFS_L2CAL_T, 8'h01);
    wr(OFS_L2CAL_M, 8'h23);
    wr(OFS_L2CAL_L, 8'h45);
    chk(loop2_zero_delay_en, 1'b1);
    wr(OFS_L2FB_L, 8'h0C);
    #1;
    chk(cal_busy, 1'b1);
    chk(cfg.loop2_active_feedback, 18'h12345);
    chk(loop2_zero_delay_en, 1'b0);
    n = 0;
    while (cal_busy === 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 100) begin
      fails++;
      end_sim();
    end
    chk(n, CAL_N);
    chk(cfg.loop2_active_feedback, 18'h0010C);
    repeat (4) @(posedge mclk);
    #1;
    chk(loop2_zero_delay_en, 1'b1);
    // Disabled calibration: a low-byte write must not start the routine.
    wr(OFS_L2FB_T, 8'h04);
    wr(OFS_L2FB_L, 8'h0D);
    repeat (2) @(posedge mclk);
    #1;
    chk(cal_busy, 1'b0);
    st(8'h0B, 1'b1, 1'b0, 1'b1, 1'b1);
    st(8'h0C, 1'b1, 1'b0, 1'b0, 1'b1);
    st(8'h0E, 1'b1, 1'b0, 1'b0, 1'b0);
    st(8'h0E, 1'b0, 1'b0, 1'b0, 1'b1);
    st(8'h0D, 1'b1, 1'b1, 1'b0, 1'b0);
    st(8'h1B, 1'b1, 1'b1, 1'b1, 1'b1);
    st(8'h1B, 1'b1, 1'b0, 1'b0, 1'b1);
    st(8'h13, 1'b0, 1'b1, 1'b1, 1'b1);
    st(8'h03, 1'b1, 1'b1, 1'b0, 1'b1);
    end_sim();
  end

  initial begin
    #2000000;
    fails++;
    end_sim();
  end
endmodule // tb
